//--- verilog/ring_queue_pkg.sv
// Constants, ring layout and types for the shared ring queue engine.
// Assumes host memory is reached by byte address, little-endian, with naturally aligned accesses.
// Notes on behaviour
// - Available index wraps as 16-bit counter.
// - Queue size at most 32768 entries.
// - Device fetches chains once index advances.
// - Readable segments precede writable segments.
// - Device returns buffers and interrupts driver.
// - Configuration change raises configuration interrupt.
// - Reset-needed status also raises that interrupt.
// - Queues live only with driver-ready, else stop.
// - Used entry holds head and written bytes.
// - Interrupt unless bit 0 of driver flags is set.
package ring_queue_pkg;
  localparam int unsigned MAX_QSIZE = 32768;
  localparam logic [15:0] MAX_QSIZE_W = 16'h8000;
  localparam logic [63:0] AVAIL_RING_OFS = 64'h0000_0000_0000_0004;
  localparam logic [63:0] USED_IDX_OFS = 64'h0000_0000_0000_0002;
  localparam logic [63:0] USED_RING_OFS = 64'h0000_0000_0000_0004;
  localparam logic [63:0] DESC_WORD1_OFS = 64'h0000_0000_0000_0008;
  localparam int unsigned RING_ENTRY_SHIFT = 1;
  localparam int unsigned USED_ELEM_SHIFT = 3;
  localparam int unsigned DESC_SHIFT = 4;
  localparam int unsigned FLAG_NEXT_BIT = 0;
  localparam int unsigned FLAG_WRITE_BIT = 1;
  localparam int unsigned NO_INTERRUPT_BIT = 0;
  localparam int unsigned AVAIL_IDX_LSB = 16;
  localparam int unsigned DESC_LEN_LSB = 0;
  localparam int unsigned DESC_FLAGS_LSB = 32;
  localparam int unsigned DESC_NEXT_LSB = 48;
  localparam int unsigned FIFO_DEPTH = 16;
  localparam logic [1:0] MEM_SIZE_16 = 2'h0;
  localparam logic [1:0] MEM_SIZE_32 = 2'h1;
  localparam logic [1:0] MEM_SIZE_64 = 2'h2;

  typedef struct packed {
    logic [15:0] head;
    logic last;
    logic writable;
    logic [31:0] len;
    logic [63:0] addr;
  } seg_s;

  localparam int unsigned SEG_W = $bits(seg_s);

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_RD_AVAIL = 4'h1,
    ST_RD_RING = 4'h2,
    ST_RD_DESC0 = 4'h3,
    ST_RD_DESC1 = 4'h4,
    ST_PUSH = 4'h5,
    ST_WR_ELEM = 4'h6,
    ST_WR_IDX = 4'h7,
    ST_RD_FLAGS = 4'h8,
    ST_ERROR = 4'h9
  } eng_state_e;
endpackage : ring_queue_pkg

//--- verilog/seg_stream_if.sv
// Valid/ready carrier for segment words between the engine and its FIFO.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
interface seg_stream_if #(parameter int unsigned W = 8);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : seg_stream_if

//--- verilog/seg_fifo.sv
// Segment FIFO with a registered output stage.
// Assumes the drain side may stall at will; the fill side sees honest back-pressure.
`timescale 1ns/10ps
module seg_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst_b,
  seg_stream_if.snk in_if,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW:0] count_q;
  logic push;
  logic pop;

  // Full only when every storage word holds data; the output register is extra
  assign in_if.ready = (count_q < (AW+1)'(DEPTH));
  assign push = in_if.valid & in_if.ready;
  // Output register refills whenever it is empty or being taken
  assign pop = (count_q != '0) & (~out_valid | out_ready);

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_if.data;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
      count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      out_valid <= 1'b0;
      out_data <= '0;
    end else if (pop) begin
      out_valid <= 1'b1;
      out_data <= mem_q[rd_ptr_q];
    end else if (out_ready) begin
      out_valid <= 1'b0;
    end
  end
endmodule : seg_fifo

//--- verilog/ring_queue_engine.sv
// Device end of one shared-memory work queue: fetches chains, streams segments, returns used entries.
// Assumes a simple host-memory master port with one outstanding access, answered by a one-cycle mem_ack.
`timescale 1ns/10ps
module ring_queue_engine (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic driver_ok,
  input wire logic [15:0] queue_size,
  input wire logic [63:0] desc_base,
  input wire logic [63:0] avail_base,
  input wire logic [63:0] used_base,
  input wire logic notify,
  input wire logic cfg_changed,
  input wire logic reset_needed_req,
  output logic mem_req,
  output logic mem_we,
  output logic [1:0] mem_size,
  output logic [63:0] mem_addr,
  output logic [63:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [63:0] mem_rdata,
  output logic seg_valid,
  input wire logic seg_ready,
  output logic [63:0] seg_addr,
  output logic [31:0] seg_len,
  output logic seg_writable,
  output logic seg_last,
  output logic [15:0] seg_head,
  input wire logic cpl_valid,
  output logic cpl_ready,
  input wire logic [15:0] cpl_head,
  input wire logic [31:0] cpl_len,
  output logic queue_irq,
  output logic cfg_irq,
  output logic reset_needed_status,
  output logic queue_live,
  output logic [15:0] used_idx
);
  ring_queue_pkg::eng_state_e state_q;
  logic [15:0] last_avail_q;
  logic [15:0] avail_idx_q;
  logic [15:0] used_idx_q;
  logic [15:0] cur_q;
  logic [15:0] head_q;
  logic [15:0] next_q;
  logic [15:0] flags_q;
  logic [63:0] addr_q;
  logic [31:0] len_q;
  logic wr_seen_q;
  logic [15:0] ret_head_q;
  logic [31:0] ret_len_q;
  logic notify_pend_q;
  logic fault;
  logic irq_fire;
  logic qsize_ok;
  logic live;
  logic issue_we;
  logic [1:0] issue_size;
  logic [63:0] issue_addr;
  logic [63:0] issue_wdata;
  logic [15:0] rd_avail_idx;
  logic [15:0] desc_flags;
  logic [15:0] desc_next;
  logic seg_is_last;
  ring_queue_pkg::seg_s seg_word;
  ring_queue_pkg::seg_s seg_out;

  seg_stream_if #(.W(ring_queue_pkg::SEG_W)) seg_if ();

  // Power-of-two sizes make the modulo a mask
  function automatic logic [15:0] ring_slot(input logic [15:0] idx, input logic [15:0] qs);
    ring_slot = idx & (qs - 16'h0001);
  endfunction : ring_slot

  function automatic logic [63:0] desc_addr(input logic [15:0] idx);
    desc_addr = desc_base + (64'(idx) << ring_queue_pkg::DESC_SHIFT);
  endfunction : desc_addr

  assign qsize_ok = (queue_size != 16'h0000) && (queue_size <= ring_queue_pkg::MAX_QSIZE_W)
    && ((queue_size & (queue_size - 16'h0001)) == 16'h0000);
  assign live = driver_ok & qsize_ok & ~reset_needed_status;
  assign rd_avail_idx = mem_rdata[ring_queue_pkg::AVAIL_IDX_LSB +: 16];
  assign desc_flags = mem_rdata[ring_queue_pkg::DESC_FLAGS_LSB +: 16];
  assign desc_next = mem_rdata[ring_queue_pkg::DESC_NEXT_LSB +: 16];
  assign seg_is_last = ~flags_q[ring_queue_pkg::FLAG_NEXT_BIT];

  always_comb begin
    seg_word.head = head_q;
    seg_word.last = seg_is_last;
    seg_word.writable = flags_q[ring_queue_pkg::FLAG_WRITE_BIT];
    seg_word.len = len_q;
    seg_word.addr = addr_q;
  end
  assign seg_if.data = seg_word;
  assign seg_if.valid = (state_q == ring_queue_pkg::ST_PUSH);

  // Memory access that each state needs
  always_comb begin
    issue_we = 1'b0;
    issue_size = ring_queue_pkg::MEM_SIZE_16;
    issue_addr = avail_base;
    issue_wdata = 64'h0000_0000_0000_0000;
    unique case (state_q)
      ring_queue_pkg::ST_RD_AVAIL: begin
        issue_size = ring_queue_pkg::MEM_SIZE_32;
      end
      ring_queue_pkg::ST_RD_RING: begin
        issue_addr = avail_base + ring_queue_pkg::AVAIL_RING_OFS
          + (64'(ring_slot(last_avail_q, queue_size)) << ring_queue_pkg::RING_ENTRY_SHIFT);
      end
      ring_queue_pkg::ST_RD_DESC0: begin
        issue_size = ring_queue_pkg::MEM_SIZE_64;
        issue_addr = desc_addr(cur_q);
      end
      ring_queue_pkg::ST_RD_DESC1: begin
        issue_size = ring_queue_pkg::MEM_SIZE_64;
        issue_addr = desc_addr(cur_q) + ring_queue_pkg::DESC_WORD1_OFS;
      end
      ring_queue_pkg::ST_WR_ELEM: begin
        issue_we = 1'b1;
        issue_size = ring_queue_pkg::MEM_SIZE_64;
        issue_addr = used_base + ring_queue_pkg::USED_RING_OFS
          + (64'(ring_slot(used_idx_q, queue_size)) << ring_queue_pkg::USED_ELEM_SHIFT);
        issue_wdata = {ret_len_q, 16'h0000, ret_head_q};
      end
      ring_queue_pkg::ST_WR_IDX: begin
        issue_we = 1'b1;
        issue_addr = used_base + ring_queue_pkg::USED_IDX_OFS;
        issue_wdata = {48'h0000_0000_0000, used_idx_q + 16'h0001};
      end
      default: begin
        issue_we = 1'b0;
      end
    endcase
  end

  // Engine sequence and host-memory master
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= ring_queue_pkg::ST_IDLE;
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_size <= ring_queue_pkg::MEM_SIZE_16;
      mem_addr <= 64'h0000_0000_0000_0000;
      mem_wdata <= 64'h0000_0000_0000_0000;
      last_avail_q <= 16'h0000;
      avail_idx_q <= 16'h0000;
      used_idx_q <= 16'h0000;
      cur_q <= 16'h0000;
      head_q <= 16'h0000;
      next_q <= 16'h0000;
      flags_q <= 16'h0000;
      addr_q <= 64'h0000_0000_0000_0000;
      len_q <= 32'h0000_0000;
      wr_seen_q <= 1'b0;
      ret_head_q <= 16'h0000;
      ret_len_q <= 32'h0000_0000;
      cpl_ready <= 1'b0;
    end else if (!live) begin
      // Abandon in-flight work; a queue dropped by driver_ok restarts from index zero
      state_q <= reset_needed_status ? ring_queue_pkg::ST_ERROR : ring_queue_pkg::ST_IDLE;
      mem_req <= 1'b0;
      cpl_ready <= 1'b0;
      if (!driver_ok) begin
        last_avail_q <= 16'h0000;
        used_idx_q <= 16'h0000;
      end
    end else begin
      if ((state_q != ring_queue_pkg::ST_IDLE) && (state_q != ring_queue_pkg::ST_PUSH)
          && (state_q != ring_queue_pkg::ST_ERROR) && !mem_req) begin
        mem_req <= 1'b1;
        mem_we <= issue_we;
        mem_size <= issue_size;
        mem_addr <= issue_addr;
        mem_wdata <= issue_wdata;
      end else if (mem_req && mem_ack) begin
        mem_req <= 1'b0;
      end
      unique case (state_q)
        ring_queue_pkg::ST_IDLE: begin
          // A return goes first only if cpl_ready is already up; otherwise a pending doorbell wins
          if (cpl_valid && cpl_ready) begin
            ret_head_q <= cpl_head;
            ret_len_q <= cpl_len;
            cpl_ready <= 1'b0;
            state_q <= ring_queue_pkg::ST_WR_ELEM;
          end else if (notify_pend_q) begin
            cpl_ready <= 1'b0;
            state_q <= ring_queue_pkg::ST_RD_AVAIL;
          end else begin
            cpl_ready <= 1'b1;
          end
        end
        ring_queue_pkg::ST_RD_AVAIL: begin
          if (mem_req && mem_ack) begin
            avail_idx_q <= rd_avail_idx;
            // Unequal means new heads, even across the 16-bit wrap
            state_q <= (rd_avail_idx != last_avail_q) ? ring_queue_pkg::ST_RD_RING
              : ring_queue_pkg::ST_IDLE;
          end
        end
        ring_queue_pkg::ST_RD_RING: begin
          if (mem_req && mem_ack) begin
            head_q <= mem_rdata[15:0];
            cur_q <= mem_rdata[15:0];
            wr_seen_q <= 1'b0;
            state_q <= ring_queue_pkg::ST_RD_DESC0;
          end
        end
        ring_queue_pkg::ST_RD_DESC0: begin
          if (mem_req && mem_ack) begin
            addr_q <= mem_rdata;
            state_q <= ring_queue_pkg::ST_RD_DESC1;
          end
        end
        ring_queue_pkg::ST_RD_DESC1: begin
          if (mem_req && mem_ack) begin
            len_q <= mem_rdata[ring_queue_pkg::DESC_LEN_LSB +: 32];
            flags_q <= desc_flags;
            next_q <= desc_next;
            state_q <= fault ? ring_queue_pkg::ST_ERROR : ring_queue_pkg::ST_PUSH;
          end
        end
        ring_queue_pkg::ST_PUSH: begin
          if (seg_if.ready) begin
            wr_seen_q <= wr_seen_q | flags_q[ring_queue_pkg::FLAG_WRITE_BIT];
            if (!seg_is_last) begin
              cur_q <= next_q;
              state_q <= ring_queue_pkg::ST_RD_DESC0;
            end else begin
              last_avail_q <= last_avail_q + 16'h0001;
              state_q <= (last_avail_q + 16'h0001 != avail_idx_q) ? ring_queue_pkg::ST_RD_RING
                : ring_queue_pkg::ST_IDLE;
            end
          end
        end
        ring_queue_pkg::ST_WR_ELEM: begin
          if (mem_req && mem_ack) begin
            state_q <= ring_queue_pkg::ST_WR_IDX;
          end
        end
        ring_queue_pkg::ST_WR_IDX: begin
          if (mem_req && mem_ack) begin
            used_idx_q <= used_idx_q + 16'h0001;
            state_q <= ring_queue_pkg::ST_RD_FLAGS;
          end
        end
        ring_queue_pkg::ST_RD_FLAGS: begin
          if (mem_req && mem_ack) begin
            state_q <= ring_queue_pkg::ST_IDLE;
          end
        end
        ring_queue_pkg::ST_ERROR: begin
          state_q <= ring_queue_pkg::ST_ERROR;
        end
        default: begin
          state_q <= ring_queue_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Malformed chain: writable then readable, or index outside the table
  assign fault = (state_q == ring_queue_pkg::ST_RD_DESC1) && mem_req && mem_ack
    && ((wr_seen_q && !desc_flags[ring_queue_pkg::FLAG_WRITE_BIT])
      || (cur_q >= queue_size)
      || (desc_flags[ring_queue_pkg::FLAG_NEXT_BIT] && (desc_next >= queue_size)));

  // Doorbell kept until the engine looks; a ring in the same cycle wins over the clear
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      notify_pend_q <= 1'b0;
    end else begin
      notify_pend_q <= (notify & live)
        | (notify_pend_q & live & ~((state_q == ring_queue_pkg::ST_IDLE) & ~(cpl_valid & cpl_ready)));
    end
  end

  // Used-ring interrupt gated by the driver's no-interrupt flag
  assign irq_fire = (state_q == ring_queue_pkg::ST_RD_FLAGS) && mem_req && mem_ack
    && !mem_rdata[ring_queue_pkg::NO_INTERRUPT_BIT];

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      queue_irq <= 1'b0;
    end else begin
      queue_irq <= irq_fire & live;
    end
  end

  // Needs-reset is sticky until device reset
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      reset_needed_status <= 1'b0;
      cfg_irq <= 1'b0;
    end else begin
      reset_needed_status <= reset_needed_status | fault | reset_needed_req;
      cfg_irq <= cfg_changed
        | (~reset_needed_status & (fault | reset_needed_req));
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      queue_live <= 1'b0;
      used_idx <= 16'h0000;
    end else begin
      queue_live <= live;
      used_idx <= used_idx_q;
    end
  end

  seg_fifo #(
    .WIDTH(ring_queue_pkg::SEG_W),
    .DEPTH(ring_queue_pkg::FIFO_DEPTH)
  ) u_seg_fifo (
    .clk(ref_clk),
    .rst_b(rst_b),
    .in_if(seg_if),
    .out_valid(seg_valid),
    .out_ready(seg_ready),
    .out_data(seg_out)
  );

  assign seg_addr = seg_out.addr;
  assign seg_len = seg_out.len;
  assign seg_writable = seg_out.writable;
  assign seg_last = seg_out.last;
  assign seg_head = seg_out.head;
endmodule : ring_queue_engine

//--- testbench/ring_queue_engine_asserts.sv
// Port-level checker for the ring queue engine.
// Assumes it is bound to the engine top; sees only its ports.
`timescale 1ns/10ps
module ring_queue_engine_asserts (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic driver_ok,
  input wire logic [63:0] avail_base,
  input wire logic [63:0] used_base,
  input wire logic cfg_changed,
  input wire logic reset_needed_req,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [1:0] mem_size,
  input wire logic [63:0] mem_addr,
  input wire logic [63:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [63:0] mem_rdata,
  input wire logic seg_valid,
  input wire logic seg_ready,
  input wire logic [63:0] seg_addr,
  input wire logic [31:0] seg_len,
  input wire logic seg_writable,
  input wire logic seg_last,
  input wire logic [15:0] seg_head,
  input wire logic queue_irq,
  input wire logic cfg_irq,
  input wire logic reset_needed_status,
  input wire logic queue_live,
  input wire logic [15:0] used_idx
);
  logic wr_seen_q;
  logic take;
  logic flag_rd;
  logic flag_clr;
  logic idx_req;
  logic idx_wr;
  assign take = seg_valid && seg_ready;
  assign flag_rd = mem_req && mem_ack && !mem_we && mem_size == ring_queue_pkg::MEM_SIZE_16 && mem_addr == avail_base;
  assign flag_clr = flag_rd && !mem_rdata[0];
  assign idx_req = mem_req && mem_we && mem_addr == used_base + ring_queue_pkg::USED_IDX_OFS;
  assign idx_wr = idx_req && mem_ack;
  // Writable seen mid-chain; cleared at chain end or queue drop
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_seen_q <= 1'b0;
    end else if (!driver_ok) begin
      wr_seen_q <= 1'b0;
    end else if (take) begin
      wr_seen_q <= seg_writable && !seg_last;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  a_reset_quiet: assert property ($rose(rst_b) |-> !mem_req && !seg_valid && !queue_live && used_idx == 16'h0000)
    else $error("outputs active right after reset");
  a_stop_when_down: assert property (!driver_ok [*2] |-> !queue_live && !mem_req)
    else $error("queue still working without driver ready");
  a_req_steady: assert property (disable iff (!rst_b || !driver_ok) mem_req && !mem_ack |=>
    mem_req && $stable(mem_addr) && $stable(mem_we) && $stable(mem_size) && $stable(mem_wdata))
    else $error("memory request changed before answer");
  a_req_gap: assert property (mem_req && mem_ack |=> !mem_req)
    else $error("no idle cycle between memory accesses");
  a_seg_steady: assert property (disable iff (!rst_b || !driver_ok) seg_valid && !seg_ready |=>
    seg_valid && $stable(seg_addr) && $stable(seg_len) && $stable(seg_head) && $stable(seg_writable))
    else $error("segment changed while stalled");
  a_read_first: assert property (take && wr_seen_q |-> seg_writable)
    else $error("readable segment after writable one");
  a_irq_cause: assert property (queue_irq |-> $past(flag_clr))
    else $error("interrupt without clear suppression flag");
  a_irq_owed: assert property (flag_clr |=> queue_irq)
    else $error("interrupt missing after used entry");
  a_used_step: assert property (used_idx != $past(used_idx) && $past(driver_ok) |->
    used_idx == $past(used_idx) + 16'h1 && $past(idx_wr, 2))
    else $error("used index moved wrongly");
  a_idx_value: assert property (idx_req |-> mem_wdata[15:0] == used_idx + 16'h1)
    else $error("used index write carries wrong value");
  a_cfg_follow: assert property (cfg_changed |-> ##[1:2] cfg_irq)
    else $error("no config interrupt after change");
  a_need_irq: assert property ($rose(reset_needed_status) |-> ##[0:2] cfg_irq)
    else $error("no config interrupt on reset needed");
  a_need_sticky: assert property (reset_needed_status |=> reset_needed_status)
    else $error("reset needed status dropped");
  a_need_req: assert property (reset_needed_req |-> ##[1:2] reset_needed_status)
    else $error("reset needed request ignored");
  c_irq: cover property (queue_irq);
  c_chain_end: cover property (take && seg_last);
  c_fault: cover property ($rose(reset_needed_status));
  c_idx_wr: cover property (idx_wr);
endmodule : ring_queue_engine_asserts

bind ring_queue_engine ring_queue_engine_asserts u_chk (.ref_clk, .rst_b, .driver_ok, .avail_base, .used_base,
  .cfg_changed, .reset_needed_req, .mem_req, .mem_we, .mem_size, .mem_addr, .mem_wdata, .mem_ack, .mem_rdata,
  .seg_valid, .seg_ready, .seg_addr, .seg_len, .seg_writable, .seg_last, .seg_head, .queue_irq, .cfg_irq,
  .reset_needed_status, .queue_live, .used_idx);

//--- testbench/host_mem_model.sv
// Host memory model answering the engine's memory port.
// Assumes byte addressing, little-endian, one access at a time.
`timescale 1ns/10ps
module host_mem_model (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [1:0] mem_size,
  input wire logic [63:0] mem_addr,
  input wire logic [63:0] mem_wdata,
  input wire logic [3:0] lat,
  output logic mem_ack,
  output logic [63:0] mem_rdata
);
  logic [7:0] mem [logic [63:0]];
  int cnt;
  int nb;
  initial begin
    mem_ack = 1'b0;
    mem_rdata = 64'h0;
    cnt = 0;
  end
  // Released data is inverted so a stale word never passes
  always @(posedge clk) begin
    #1;
    nb = 2 << mem_size;
    if (mem_ack === 1'b1) begin
      mem_ack = 1'b0;
      mem_rdata = ~mem_rdata;
    end else if (mem_req === 1'b1 && rst_b === 1'b1 && cnt < lat) begin
      cnt++;
    end else if (mem_req === 1'b1 && rst_b === 1'b1) begin
      cnt = 0;
      mem_ack = 1'b1;
      for (int i = 0; i < 8; i++) begin
        if (mem_we && i < nb) mem[mem_addr + i] = mem_wdata[8*i +: 8];
        // Host stores land before any index update is read
        if (!mem_we) mem_rdata[8*i +: 8] = (i < nb && mem.exists(mem_addr + i)) ? mem[mem_addr + i] : 8'h00;
      end
    end else begin
      cnt = 0;
    end
  end
endmodule : host_mem_model

//--- testbench/shared_ring_queue_engine_test.sv
// Self-checking bench for the ring queue engine.
// Assumes the host memory model stands on the memory port.
`timescale 1ns/10ps
module shared_ring_queue_engine_test;
  localparam logic [63:0] desc_b = 64'h0000_0000_0001_0000;
  localparam logic [63:0] avail_b = 64'h0000_0000_0000_2000;
  localparam logic [63:0] used_b = 64'h0000_0000_0000_3000;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic driver_ok = 1'b0, notify = 1'b0, cfg_changed = 1'b0, reset_needed_req = 1'b0;
  logic seg_ready = 1'b0, cpl_valid = 1'b0;
  logic [15:0] queue_size = 16'h0020, cpl_head = 16'h0000;
  logic [31:0] cpl_len = 32'h0;
  logic [3:0] lat = 4'h0;
  logic mem_req, mem_we, mem_ack, seg_valid, seg_writable, seg_last, cpl_ready;
  logic queue_irq, cfg_irq, reset_needed_status, queue_live;
  logic [1:0] mem_size;
  logic [63:0] mem_addr, mem_wdata, mem_rdata, seg_addr;
  logic [31:0] seg_len;
  logic [15:0] seg_head, used_idx;
  int failures = 0, num_checks = 0, irq_n = 0, cfg_n = 0, req_n = 0, cyc = 0, k0;
  always #2.5 ref_clk = ~ref_clk;
  ring_queue_engine DUT (.ref_clk, .rst_b, .driver_ok, .queue_size, .desc_base(desc_b), .avail_base(avail_b),
    .used_base(used_b), .notify, .cfg_changed, .reset_needed_req, .mem_req, .mem_we, .mem_size, .mem_addr,
    .mem_wdata, .mem_ack, .mem_rdata, .seg_valid, .seg_ready, .seg_addr, .seg_len, .seg_writable, .seg_last,
    .seg_head, .cpl_valid, .cpl_ready, .cpl_head, .cpl_len, .queue_irq, .cfg_irq, .reset_needed_status,
    .queue_live, .used_idx);
  host_mem_model pm (.clk(ref_clk), .rst_b, .mem_req, .mem_we, .mem_size, .mem_addr, .mem_wdata, .lat,
    .mem_ack, .mem_rdata);
  task automatic close_out();
    $display("checks %0d, mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : close_out
  // Cycle ceiling well above the thousand or so the run needs
  always @(posedge ref_clk) begin
    cyc++;
    if (queue_irq === 1'b1) irq_n++;
    if (cfg_irq === 1'b1) cfg_n++;
    if (mem_req === 1'b1 && mem_ack === 1'b1) req_n++;
    if (cyc == 30000) begin
      failures++;
      close_out();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : tick
  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string msg);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask : chk
  task automatic put64(input logic [63:0] a, input logic [63:0] d);
    for (int i = 0; i < 8; i++) pm.mem[a + i] = d[8*i +: 8];
  endtask : put64
  task automatic put16(input logic [63:0] a, input logic [15:0] d);
    pm.mem[a] = d[7:0];
    pm.mem[a + 1] = d[15:8];
  endtask : put16
  function automatic logic [63:0] get64(input logic [63:0] a);
    logic [63:0] d;
    for (int i = 0; i < 8; i++) d[8*i +: 8] = pm.mem.exists(a + i) ? pm.mem[a + i] : 8'hXX;
    return d;
  endfunction : get64
  function automatic logic [63:0] dadr(input logic [15:0] d);
    return 64'h0000_0000_0050_0000 + (64'(d) << 8);
  endfunction : dadr
  task automatic mk_desc(input logic [15:0] i, input logic [15:0] fl, input logic [15:0] nx);
    put64(desc_b + (64'(i) << 4), dadr(i));
    put64(desc_b + (64'(i) << 4) + 64'h8, {nx, fl, 32'h10 + 32'(i)});
  endtask : mk_desc
  task automatic pulse_notify();
    notify = 1'b1;
    tick(1);
    notify = 1'b0;
  endtask : pulse_notify
  task automatic rx(input logic [15:0] h, input logic [15:0] d, input logic wr, input logic lst);
    for (int n = 0; n < 300 && seg_valid !== 1'b1; n++) tick(1);
    chk(seg_head, h, "segment head");
    chk(seg_addr, dadr(d), "segment address");
    chk(seg_len, 32'h10 + 32'(d), "segment length");
    chk(seg_writable, wr, "segment direction");
    chk(seg_last, lst, "segment end");
    tick(1);
  endtask : rx
  task automatic cpl(input logic [15:0] h, input logic [15:0] slot, input int irqs);
    cpl_valid = 1'b1;
    cpl_head = h;
    cpl_len = 32'h40 + 32'(h);
    for (int n = 0; n < 300 && cpl_ready !== 1'b1; n++) tick(1);
    tick(1);
    cpl_valid = 1'b0;
    for (int n = 0; n < 300 && used_idx !== slot + 16'h1; n++) tick(1);
    tick(12);
    chk(used_idx, slot + 16'h1, "used index");
    chk(get64(used_b + 64'h4 + (64'(slot) << 3)), {cpl_len, 16'h0000, h}, "used entry");
    chk(irq_n, irqs, "queue interrupt count");
  endtask : cpl
  initial begin
    tick(12);
    rst_b = 1'b1;
    tick(1);
    chk({queue_live, mem_req, seg_valid, reset_needed_status, used_idx}, 64'h0, "outputs after reset");
    driver_ok = 1'b1;
    tick(3);
    chk(queue_live, 1'b1, "queue not live");
    // Six three-part chains plus an unpublished one in slot 6
    for (int k = 0; k < 7; k++) begin
      mk_desc(16'(3*k), 16'h0001, 16'(3*k + 1));
      mk_desc(16'(3*k + 1), 16'h0003, 16'(3*k + 2));
      mk_desc(16'(3*k + 2), 16'h0002, 16'h0000);
      put16(avail_b + 64'h4 + 64'(2*k), 16'(3*k));
    end
    put16(avail_b, 16'h0000);
    put16(avail_b + 64'h2, 16'h0006);
    pulse_notify();
    tick(600);
    chk({seg_valid, mem_req}, 2'b10, "engine not stalled by full buffer");
    seg_ready = 1'b1;
    for (int k = 0; k < 6; k++) begin
      rx(16'(3*k), 16'(3*k), 1'b0, 1'b0);
      rx(16'(3*k), 16'(3*k + 1), 1'b1, 1'b0);
      rx(16'(3*k), 16'(3*k + 2), 1'b1, 1'b1);
    end
    tick(100);
    chk(seg_valid, 1'b0, "unpublished chain fetched");
    lat = 4'h3;
    for (int k = 0; k < 6; k++) begin
      if (k == 3) put16(avail_b, 16'h0001);
      cpl(16'(3*k), 16'(k), k < 3 ? k + 1 : 3);
    end
    cfg_changed = 1'b1;
    tick(1);
    cfg_changed = 1'b0;
    tick(4);
    chk(cfg_n, 1, "config interrupt");
    driver_ok = 1'b0;
    tick(3);
    chk({queue_live, used_idx}, 17'h0, "queue still live");
    k0 = req_n;
    pulse_notify();
    tick(30);
    chk(req_n, k0, "memory used while not live");
    driver_ok = 1'b1;
    tick(3);
    mk_desc(16'h0014, 16'h0003, 16'h0015);
    mk_desc(16'h0015, 16'h0000, 16'h0000);
    put16(avail_b + 64'h4, 16'h0014);
    put16(avail_b + 64'h2, 16'h0001);
    pulse_notify();
    for (int n = 0; n < 300 && reset_needed_status !== 1'b1; n++) tick(1);
    tick(4);
    chk({reset_needed_status, 8'(cfg_n)}, 9'h102, "misordered chain accepted");
    rst_b = 1'b0;
    tick(2);
    rst_b = 1'b1;
    tick(1);
    chk(reset_needed_status, 1'b0, "status survives reset");
    reset_needed_req = 1'b1;
    tick(1);
    reset_needed_req = 1'b0;
    tick(4);
    chk({reset_needed_status, 8'(cfg_n)}, 9'h103, "reset needed request");
    close_out();
  end
endmodule : shared_ring_queue_engine_test
